// ### bench/aorc_output_routing_asserts.sv
// watches the routing block from its ports only
module aorc_output_routing_asserts (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       sclIn,
    input wire logic       sdaOe,
    input wire logic [3:0] pwmChan,
    input wire logic [3:0] pwmPinOut,
    input wire logic       chanFourLeftPostBiquad,
    input wire logic       gainLimitBandOneEn,
    input wire logic       gainLimitBandTwoEn,
    input wire logic [3:0] switchingRateCode,
    input wire logic       pwmSwitchTick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] sclHighCnt_q;   // cycles the serial clock has stayed high

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // commits land a few cycles after a serial clock fall, never late
    // in a long high phase, so a saturating count marks quiet time
    always @(posedge sys_clk) begin
        if (rst || !sclIn) begin
            sclHighCnt_q <= 4'h0;
        end else if (sclHighCnt_q != 4'hF) begin
            sclHighCnt_q <= sclHighCnt_q + 4'h1;
        end
    end

    reset_cfg_a: assert property (disable iff (1'b0) rst |=>
        chanFourLeftPostBiquad && !gainLimitBandOneEn && !gainLimitBandTwoEn
        && switchingRateCode == 4'h8) else $error("bad config after reset");
    reset_out_a: assert property (disable iff (1'b0) rst |=>
        pwmPinOut == 4'h0 && !pwmSwitchTick && !sdaOe)
        else $error("outputs active in reset");
    rate_legal_a: assert property (
        switchingRateCode inside {[4'h6:4'h9]}) else $error("rate code bad");
    xbar_ones_a: assert property (
        !$past(rst) && $past(pwmChan) == 4'hF |-> pwmPinOut == 4'hF)
        else $error("pin missed a high channel");
    xbar_zeros_a: assert property (
        !$past(rst) && $past(pwmChan) == 4'h0 |-> pwmPinOut == 4'h0)
        else $error("pin high with all channels low");
    cfg_quiet_a: assert property (sclHighCnt_q >= 4'hA |->
        $stable({chanFourLeftPostBiquad, gainLimitBandOneEn,
        gainLimitBandTwoEn, switchingRateCode}))
        else $error("config moved without a bus edge");
    sda_quiet_a: assert property (
        sclHighCnt_q >= 4'h6 |-> $stable(sdaOe))
        else $error("data line moved in clock high");
    tick_pulse_a: assert property (
        pwmSwitchTick |=> !pwmSwitchTick) else $error("tick too long");
endmodule

bind aorc_output_routing aorc_output_routing_asserts chk (.sys_clk, .rst,
    .sclIn, .sdaOe, .pwmChan, .pwmPinOut, .chanFourLeftPostBiquad,
    .gainLimitBandOneEn, .gainLimitBandTwoEn, .switchingRateCode,
    .pwmSwitchTick);

// ### bench/tb_top.sv
`include "aorc_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk;        // 10 MHz clock
    logic       rst;            // synchronous reset
    logic       sclIn;          // serial clock from the bench master
    logic       masterSda;      // master data level, 1 = released
    logic [3:0] pwmChan;        // internal channel levels
    logic       sampleRateTick; // one pulse per sample
    wire        sdaOut, sdaOe, chanFour, bandOne, bandTwo, switchTick;
    wire  [3:0] pwmPinOut, rateCode;
    wire        sdaWire;        // resolved open drain line
    int         miscompares;
    int         total_checks;

    // pull-up line: low when either side pulls
    assign sdaWire = masterSda & (sdaOe ? sdaOut : 1'b1);

    aorc_output_routing dut (.sys_clk(sys_clk), .rst(rst), .sclIn(sclIn),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelect(1'b0),
        .pwmChan(pwmChan), .sampleRateTick(sampleRateTick),
        .pwmPinOut(pwmPinOut), .chanFourLeftPostBiquad(chanFour),
        .gainLimitBandOneEn(bandOne), .gainLimitBandTwoEn(bandTwo),
        .switchingRateCode(rateCode), .pwmSwitchTick(switchTick));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkNib(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one serial bit: 8 cycles low, 8 high, sampled mid high
    task automatic bitPulse(input logic bo, output logic bi);
        tick(4);
        masterSda = bo;
        tick(4);
        sclIn = 1'b1;
        tick(4);
        bi = sdaWire;
        tick(4);
        sclIn = 1'b0;
    endtask

    // also serves as repeated start since it raises data first
    task automatic startCond;
        tick(4);
        masterSda = 1'b1;
        tick(4);
        sclIn = 1'b1;
        tick(8);
        masterSda = 1'b0;
        tick(8);
        sclIn = 1'b0;
    endtask

    task automatic stopCond;
        tick(4);
        masterSda = 1'b0;
        tick(4);
        sclIn = 1'b1;
        tick(8);
        masterSda = 1'b1;
        tick(8);
    endtask

    task automatic sendByte(input logic [7:0] b);
        logic x;
        for (int i = 7; i >= 0; i--) bitPulse(b[i], x);
        bitPulse(1'b1, x);
    endtask

    task automatic recvByte(output logic [7:0] b, input logic last);
        logic x;
        for (int i = 7; i >= 0; i--) bitPulse(1'b1, b[i]);
        bitPulse(last, x);
    endtask

    task automatic regWrite(input logic [7:0] idx, input logic [31:0] d);
        startCond();
        sendByte(8'h54);
        sendByte(idx);
        for (int k = 3; k >= 0; k--) sendByte(d[8*k +: 8]);
        stopCond();
    endtask

    task automatic regRead(input logic [7:0] idx, output logic [31:0] d);
        startCond();
        sendByte(8'h54);
        sendByte(idx);
        startCond();
        sendByte(8'h55);
        for (int k = 3; k >= 0; k--) recvByte(d[8*k +: 8], k == 0);
        stopCond();
    endtask

    // walk one-hot and all-high channel patterns through the pins
    task automatic checkXbar(input logic [1:0] fa, fb, fc, fd);
        logic [3:0] pat;
        for (int p = 0; p < 5; p++) begin
            pat = (p == 4) ? 4'hF : (4'h1 << p);
            pwmChan = pat;
            tick(1);
            chkNib(pwmPinOut, {pat[fd], pat[fc], pat[fb], pat[fa]});
        end
        pwmChan = 4'h0;
    endtask

    task automatic checkDefaults;
        logic [31:0] rd;
        regRead(`AORC_ADDR_SUBCHAN, rd);
        chkWord(rd, `AORC_RST_SUBCHAN);
        regRead(`AORC_ADDR_XBAR, rd);
        chkWord(rd, `AORC_RST_XBAR);
        regRead(`AORC_ADDR_GAINLIM, rd);
        chkWord(rd, `AORC_RST_GAINLIM);
        regRead(`AORC_ADDR_RATE, rd);
        chkWord(rd, `AORC_RST_RATE);
        chkNib({bandTwo, bandOne, chanFour, 1'b0}, 4'h2);
        checkXbar(2'h0, 2'h2, 2'h1, 2'h3);
    endtask

    // rotations cover every code on every pin, last one shares channel 4
    task automatic xbarScen;
        logic [1:0]  f;
        logic [31:0] w, rd;
        for (int k = 0; k < 5; k++) begin
            f = k[1:0];
            w = (k == 4) ? 32'h01333345 : {8'h01, 2'b00, f, 2'b00, f + 2'h1,
                2'b00, f + 2'h2, 2'b00, f + 2'h3, 8'h45};
            regWrite(`AORC_ADDR_XBAR, w);
            regRead(`AORC_ADDR_XBAR, rd);
            chkWord(rd, w);
            checkXbar(w[21:20], w[17:16], w[13:12], w[9:8]);
        end
    endtask

    task automatic cfgScen;
        logic [31:0] rd;
        regWrite(`AORC_ADDR_SUBCHAN, 32'h00004203);
        chkNib({3'h0, chanFour}, 4'h0);
        regRead(`AORC_ADDR_SUBCHAN, rd);
        chkWord(rd, 32'h00004203);
        regWrite(`AORC_ADDR_SUBCHAN, 32'h00004303);
        chkNib({3'h0, chanFour}, 4'h1);
        for (int g = 0; g < 4; g++) begin
            regWrite(`AORC_ADDR_GAINLIM, 32'h00020000 | g);
            chkNib({2'h0, bandTwo, bandOne}, g[3:0]);
        end
        // unmapped index must not disturb mapped state
        regWrite(8'h30, 32'hFFFFFFFF);
        regRead(8'h30, rd);
        chkWord(rd, 32'h0);
        regRead(`AORC_ADDR_GAINLIM, rd);
        chkWord(rd, 32'h00020003);
    endtask

    // 504 cycles per sample divides evenly by every legal multiple
    task automatic rateScen;
        logic [3:0]  codes [4] = '{4'h6, 4'h7, 4'h9, 4'h8};
        logic [31:0] rd;
        int          n;
        foreach (codes[i]) begin
            regWrite(`AORC_ADDR_RATE, {28'h0, codes[i]});
            chkNib(rateCode, codes[i]);
            n = 0;
            for (int p = 0; p < 4; p++) begin
                for (int c = 0; c < 504; c++) begin
                    sampleRateTick = (c == 0);
                    tick(1);
                    if (p == 3 && switchTick === 1'b1) n++;
                end
            end
            sampleRateTick = 1'b0;
            chkWord(n, {28'h0, codes[i]});
        end
        regWrite(`AORC_ADDR_RATE, 32'h0000000A);
        regWrite(`AORC_ADDR_RATE, 32'h00000005);
        regRead(`AORC_ADDR_RATE, rd);
        chkWord(rd, 32'h00000008);
    endtask

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        sclIn = 1'b1;
        masterSda = 1'b1;
        pwmChan = 4'h0;
        sampleRateTick = 1'b0;
        miscompares = 0;
        total_checks = 0;
        tick(2);
        rst = 1'b0;
        tick(3);
        checkDefaults();
        xbarScen();
        cfgScen();
        rateScen();
        // second reset in mid-run must restore every default
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(3);
        checkDefaults();
        final_report();
    end
endmodule

// ### hdl/aorc_output_routing.v
`include "aorc_regs.vh"

// What this block does
// - bit 8 picks fourth channel source
// - bits 21..20 route channel to pin A
// - bits 17..16 route channel to pin B
// - bits 13..12 route channel to pin C
// - bits 9..8 route channel to pin D
// - field value is channel number minus one
// - any channel to any pin, independently
// - reset routes pins to 1,3,2,4
// - bit 0 enables gain limit band one
// - bit 1 enables gain limit band two
// - switching rate is multiple of sample rate
// - codes 6..9 select multiple, eight default
module aorc_output_routing (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       sclIn,
    input  wire       sdaIn,
    output wire       sdaOut,
    output wire       sdaOe,
    input  wire       addrSelect,
    input  wire [3:0] pwmChan,
    input  wire       sampleRateTick,
    output wire [3:0] pwmPinOut,
    output wire       chanFourLeftPostBiquad,
    output wire       gainLimitBandOneEn,
    output wire       gainLimitBandTwoEn,
    output wire [3:0] switchingRateCode,
    output wire       pwmSwitchTick
);

    // serial port state codes, one-hot
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_SUB  = 5'h04;
    localparam [4:0] ST_WR   = 5'h08;
    localparam [4:0] ST_RD   = 5'h10;
    localparam [31:0] RST_SUB = `AORC_RST_SUBCHAN, RST_RATE = `AORC_RST_RATE;

    // pin synchronisers: stage 1, stage 2, and a history stage on clock and data
    reg        sclS1_q;            // first stage, read only by stage 2
    reg        sclS2_q;            // settled clock level
    reg        sclS3_q;            // previous settled level
    reg        sdaS1_q;            // first stage, read only by stage 2
    reg        sdaS2_q;            // settled data level
    reg        sdaS3_q;            // previous settled level
    reg        adrS1_q;            // address strap stage 1
    reg        adrS2_q;            // address strap stage 2

    // serial port engine
    reg  [4:0]  state_q;           // current transfer phase
    reg  [2:0]  bitCnt_q;          // bit within the byte
    reg  [1:0]  byteCnt_q;         // data byte within a write
    reg         byteEnd_q;         // eighth bit seen, ack slot next
    reg         ackPhase_q;        // inside the ninth clock
    reg  [7:0]  shift_q;           // received byte
    reg  [7:0]  subAddr_q;         // register index
    reg  [23:0] wordBuf_q;         // first three bytes of a write
    reg  [31:0] txWord_q;          // read word, msb goes first
    reg         sdaOe_q;           // pulls the data line low
    reg         wrStb_q;           // one-cycle write commit
    reg  [31:0] wrData_q;          // word to commit
    reg  [7:0]  wrAddr_q;          // index to commit to

    // configuration fields
    reg         subSel_q;          // fourth channel source
    reg  [7:0]  xbar_q;            // pin A..D selects, two bits each
    reg  [1:0]  glim_q;            // gain limit band enables
    reg  [3:0]  rate_q;            // switching multiple

    // outputs from flops
    reg  [3:0]  pinOut_q;          // routed pwm levels
    reg         swTick_q;          // switching rate pulse

    // switching rate generator
    reg  [`AORC_PERIOD_W-1:0] periodCnt_q;  // cycles since last fs tick
    reg  [`AORC_PERIOD_W-1:0] period_q;     // last measured fs period
    reg  [`AORC_PERIOD_W-1:0] acc_q;        // phase accumulator

    // edge detection uses settled stages only
    wire sclRise = sclS2_q & ~sclS3_q;
    wire sclFall = ~sclS2_q & sclS3_q;
    wire startCond = sclS2_q & sclS3_q & sdaS3_q & ~sdaS2_q;
    wire stopCond  = sclS2_q & sclS3_q & ~sdaS3_q & sdaS2_q;
    wire [6:0] myAddr = {`AORC_SLAVE_BASE, adrS2_q};

    // read image of a register: reserved bits at fixed values
    function [31:0] regRead;
        input [7:0] idx;
        begin
            case (idx)
                `AORC_ADDR_SUBCHAN: begin
                    regRead = `AORC_RST_SUBCHAN;
                    regRead[`AORC_SUBCHAN_BIT] = subSel_q;
                end
                `AORC_ADDR_XBAR: begin
                    regRead = `AORC_RST_XBAR;
                    regRead[`AORC_XBAR_A_LO+1:`AORC_XBAR_A_LO] = xbar_q[7:6];
                    regRead[`AORC_XBAR_B_LO+1:`AORC_XBAR_B_LO] = xbar_q[5:4];
                    regRead[`AORC_XBAR_C_LO+1:`AORC_XBAR_C_LO] = xbar_q[3:2];
                    regRead[`AORC_XBAR_D_LO+1:`AORC_XBAR_D_LO] = xbar_q[1:0];
                end
                `AORC_ADDR_GAINLIM: begin
                    regRead = `AORC_RST_GAINLIM;
                    regRead[`AORC_GLIM_TWO_BIT:`AORC_GLIM_ONE_BIT] = glim_q;
                end
                `AORC_ADDR_RATE: begin
                    regRead = `AORC_RST_RATE;
                    regRead[`AORC_RATE_HI:0] = rate_q;
                end
                default: begin
                    // unmapped index reads as zero
                    regRead = 32'h00000000;
                end
            endcase
        end
    endfunction

    // two-flop synchronisers for the serial clock, serial data and address strap pins
    always @(posedge sys_clk) begin
        if (rst) begin
            sclS1_q <= 1'b1;
            sclS2_q <= 1'b1;
            sclS3_q <= 1'b1;
            sdaS1_q <= 1'b1;
            sdaS2_q <= 1'b1;
            sdaS3_q <= 1'b1;
            adrS1_q <= 1'b0;
            adrS2_q <= 1'b0;
        end else begin
            sclS1_q <= sclIn;
            sclS2_q <= sclS1_q;
            sclS3_q <= sclS2_q;
            sdaS1_q <= sdaIn;
            sdaS2_q <= sdaS1_q;
            sdaS3_q <= sdaS2_q;
            adrS1_q <= addrSelect;
            adrS2_q <= adrS1_q;
        end
    end

    // serial port: sample on clock rise, change the data line on fall
    always @(posedge sys_clk) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            bitCnt_q   <= 3'h0;
            byteCnt_q  <= 2'h0;
            byteEnd_q  <= 1'b0;
            ackPhase_q <= 1'b0;
            shift_q    <= 8'h00;
            subAddr_q  <= 8'h00;
            wordBuf_q  <= 24'h000000;
            txWord_q   <= 32'h00000000;
            sdaOe_q    <= 1'b0;
            wrStb_q    <= 1'b0;
            wrData_q   <= 32'h00000000;
            wrAddr_q   <= 8'h00;
        end else begin
            wrStb_q <= 1'b0;
            if (startCond) begin
                // start or repeated start: expect an address byte
                state_q    <= ST_ADDR;
                bitCnt_q   <= 3'h0;
                byteEnd_q  <= 1'b0;
                ackPhase_q <= 1'b0;
                sdaOe_q    <= 1'b0;
            end else if (stopCond) begin
                // stop ends any transfer, a partial write is dropped
                state_q    <= ST_IDLE;
                byteEnd_q  <= 1'b0;
                ackPhase_q <= 1'b0;
                sdaOe_q    <= 1'b0;
            end else if (sclRise && state_q != ST_IDLE) begin
                if (ackPhase_q) begin
                    // master nack after a read byte ends the read
                    if (state_q == ST_RD && sdaS2_q) begin
                        state_q <= ST_IDLE;
                    end
                end else begin
                    shift_q  <= {shift_q[6:0], sdaS2_q};
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (state_q == ST_RD) begin
                        txWord_q <= {txWord_q[30:0], 1'b0};
                    end
                    if (bitCnt_q == 3'h7) begin
                        byteEnd_q <= 1'b1;
                    end
                end
            end else if (sclFall && state_q != ST_IDLE) begin
                if (byteEnd_q) begin
                    // ninth clock: ack what we took, release on a read
                    byteEnd_q  <= 1'b0;
                    ackPhase_q <= 1'b1;
                    case (state_q)
                        ST_ADDR: begin
                            if (shift_q[7:1] == myAddr) begin
                                sdaOe_q <= 1'b1;
                                if (shift_q[0]) begin
                                    state_q  <= ST_RD;
                                    txWord_q <= regRead(subAddr_q);
                                end else begin
                                    state_q <= ST_SUB;
                                end
                            end else begin
                                // not us: stay off the bus until the next start
                                state_q <= ST_IDLE;
                            end
                        end
                        ST_SUB: begin
                            sdaOe_q   <= 1'b1;
                            subAddr_q <= shift_q;
                            byteCnt_q <= 2'h0;
                            state_q   <= ST_WR;
                        end
                        ST_WR: begin
                            // bytes arrive msb first; commit on the fourth
                            sdaOe_q   <= 1'b1;
                            wordBuf_q <= {wordBuf_q[15:0], shift_q};
                            byteCnt_q <= byteCnt_q + 2'h1;
                            if (byteCnt_q == 2'h3) begin
                                wrStb_q  <= 1'b1;
                                wrData_q <= {wordBuf_q, shift_q};
                                wrAddr_q <= subAddr_q;
                            end
                        end
                        ST_RD: begin
                            sdaOe_q <= 1'b0;
                        end
                        default: begin
                            sdaOe_q <= 1'b0;
                        end
                    endcase
                end else if (ackPhase_q) begin
                    // end of ack slot: read drives the next msb
                    ackPhase_q <= 1'b0;
                    sdaOe_q    <= (state_q == ST_RD) ? ~txWord_q[31] : 1'b0;
                end else if (state_q == ST_RD) begin
                    sdaOe_q <= ~txWord_q[31];
                end
            end
        end
    end

    // register file: only documented fields are stored
    always @(posedge sys_clk) begin
        if (rst) begin
            subSel_q <= RST_SUB[`AORC_SUBCHAN_BIT];
            xbar_q   <= {2'h0, 2'h2, 2'h1, 2'h3};
            glim_q   <= 2'h0;
            rate_q   <= RST_RATE[`AORC_RATE_HI:0];
        end else if (wrStb_q) begin
            case (wrAddr_q)
                `AORC_ADDR_SUBCHAN: begin
                    subSel_q <= wrData_q[`AORC_SUBCHAN_BIT];
                end
                `AORC_ADDR_XBAR: begin
                    // every field free to name any channel
                    xbar_q <= {wrData_q[`AORC_XBAR_A_LO+1:`AORC_XBAR_A_LO],
                               wrData_q[`AORC_XBAR_B_LO+1:`AORC_XBAR_B_LO],
                               wrData_q[`AORC_XBAR_C_LO+1:`AORC_XBAR_C_LO],
                               wrData_q[`AORC_XBAR_D_LO+1:`AORC_XBAR_D_LO]};
                end
                `AORC_ADDR_GAINLIM: begin
                    glim_q <= wrData_q[`AORC_GLIM_TWO_BIT:`AORC_GLIM_ONE_BIT];
                end
                `AORC_ADDR_RATE: begin
                    // reserved codes leave the multiple unchanged
                    if (wrData_q[`AORC_RATE_HI:0] >= `AORC_RATE_MIN &&
                        wrData_q[`AORC_RATE_HI:0] <= `AORC_RATE_MAX) begin
                        rate_q <= wrData_q[`AORC_RATE_HI:0];
                    end
                end
                default: begin
                    rate_q <= rate_q;   // other indices: write dropped
                end
            endcase
        end
    end

    // output crossbar, one registered mux per pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gPin
            // pin A uses xbar_q[7:6] down to pin D at xbar_q[1:0]
            always @(posedge sys_clk) begin
                if (rst) begin
                    pinOut_q[gi] <= 1'b0;
                end else begin
                    pinOut_q[gi] <= pwmChan[xbar_q[7-2*gi -: 2]];
                end
            end
        end
    endgenerate

    // switching rate: measure fs period, then a phase accumulator
    // stepping by the multiple emits that many pulses per period.
    // the multiple may be changed live, but the host is expected to
    // set it while the outputs are shut down
    always @(posedge sys_clk) begin
        if (rst) begin
            periodCnt_q <= {`AORC_PERIOD_W{1'b0}};
            period_q    <= {`AORC_PERIOD_W{1'b0}};
            acc_q       <= {`AORC_PERIOD_W{1'b0}};
            swTick_q    <= 1'b0;
        end else begin
            swTick_q <= 1'b0;
            if (sampleRateTick) begin
                // realign to each sample so error never accumulates
                period_q    <= periodCnt_q + 1'b1;
                periodCnt_q <= {`AORC_PERIOD_W{1'b0}};
                acc_q       <= {`AORC_PERIOD_W{1'b0}};
                swTick_q    <= (period_q != {`AORC_PERIOD_W{1'b0}});
            end else begin
                periodCnt_q <= periodCnt_q + 1'b1;
                if (period_q != {`AORC_PERIOD_W{1'b0}}) begin
                    if (acc_q + rate_q >= period_q) begin
                        acc_q    <= acc_q + rate_q - period_q;
                        swTick_q <= 1'b1;
                    end else begin
                        acc_q <= acc_q + rate_q;
                    end
                end
            end
        end
    end

    assign sdaOut                 = 1'b0;   // open drain: only pulls low
    assign sdaOe                  = sdaOe_q;
    assign pwmPinOut              = pinOut_q;
    assign chanFourLeftPostBiquad = subSel_q;
    assign gainLimitBandOneEn     = glim_q[0];
    assign gainLimitBandTwoEn     = glim_q[1];
    assign switchingRateCode      = rate_q;
    assign pwmSwitchTick          = swTick_q;

endmodule

// ### pkg/aorc_regs.vh
`ifndef AORC_REGS_VH
`define AORC_REGS_VH

// register indices on the serial control port (one byte subaddress)
`define AORC_ADDR_SUBCHAN       8'h21
`define AORC_ADDR_XBAR          8'h25
`define AORC_ADDR_GAINLIM       8'h46
`define AORC_ADDR_RATE          8'h4F

// reset images, reserved bits included at their fixed values
`define AORC_RST_SUBCHAN        32'h00004303
`define AORC_RST_XBAR           32'h01021345
`define AORC_RST_GAINLIM        32'h00020000
`define AORC_RST_RATE           32'h00000008

// fourth channel source select bit
`define AORC_SUBCHAN_BIT        8

// crossbar field low bits, pin A to pin D
`define AORC_XBAR_A_LO          20
`define AORC_XBAR_B_LO          16
`define AORC_XBAR_C_LO          12
`define AORC_XBAR_D_LO          8

// gain limiter band enables
`define AORC_GLIM_ONE_BIT       0
`define AORC_GLIM_TWO_BIT       1

// switching rate code field and legal codes
`define AORC_RATE_HI            3
`define AORC_RATE_MIN           4'h6
`define AORC_RATE_MAX           4'h9

// serial control port 7-bit address, low bit comes from a pin
`define AORC_SLAVE_BASE         6'h15

// width of the sample period measurement
`define AORC_PERIOD_W           16

`endif
